// >>> pkg/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define PMC_POWER_CONTROL_IDX 10'h087
`define PMC_CTRL_IDX 10'h088
`define PMC_STAT_IDX 10'h089
`define PMC_POWER_CONTROL_RST 8'h00
`define PMC_CTRL_RST 8'h00

// ==========================================================
// Power control fields
// ==========================================================
`define PMC_B_IDLE 0
`define PMC_B_PD 1
`define PMC_B_UF_LO 2
`define PMC_B_UF_HI 3
`define PMC_B_COLD 4
`define PMC_B_WTIME 5
`define PMC_B_FESEL 6
`define PMC_B_BAUD2 7

// ==========================================================
// Auxiliary control fields
// ==========================================================
`define PMC_B_ENA 0
`define PMC_B_ENB 1
`define PMC_B_TYPA 2
`define PMC_B_TYPB 3
`define PMC_B_WDI 4

// ==========================================================
// Start-up timing
// ==========================================================
`define PMC_CLK_MHZ 50
`define PMC_SUT_RC0_US 16
`define PMC_SUT_RC1_US 512
`define PMC_SUT_RC2_US 1024
`define PMC_SUT_RC3_US 4096
`define PMC_SUT_XT0_US 1024
`define PMC_SUT_XT1_US 2048
`define PMC_SUT_XT2_US 4096
`define PMC_SUT_XT3_US 16384
`define PMC_RST_PULSE_CYC 2'd2
`define PMC_TMR_W 20

`endif

// >>> pkg/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_ST_RUN,
    PMC_ST_IDLE,
    PMC_ST_PD,
    PMC_ST_WAKE_T,
    PMC_ST_WAKE_E,
    PMC_ST_WAKE_R,
    PMC_ST_RST_HOLD,
    PMC_ST_RST_PULSE
  } pmc_state_t;
endpackage : pmc_pkg
`default_nettype wire

// >>> hdl/pmc_power_mode_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"

module pmc_power_mode_controller #(
  parameter int unsigned SUT_RC0 = `PMC_SUT_RC0_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_RC1 = `PMC_SUT_RC1_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_RC2 = `PMC_SUT_RC2_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_RC3 = `PMC_SUT_RC3_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_XT0 = `PMC_SUT_XT0_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_XT1 = `PMC_SUT_XT1_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_XT2 = `PMC_SUT_XT2_US * `PMC_CLK_MHZ,
  parameter int unsigned SUT_XT3 = `PMC_SUT_XT3_US * `PMC_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic warm_rst,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic rst_pin,
  input wire logic [1:0] sut_fuse,
  input wire logic crystal_sel,
  input wire logic fe_event,
  input wire logic fe_clear,
  input wire logic serial_mode_bit,
  output logic serial_bit7,
  output logic baud_double_bit,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic wdt_run,
  output logic osc_en,
  output logic bod_en,
  output logic flash_pd,
  output logic cpu_rst,
  output logic wake_irq,
  output logic [1:0] wake_src,
  output var pmc_pkg::pmc_state_t mode_state
);
  import pmc_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  localparam int TW = `PMC_TMR_W;
  pmc_state_t state_r;
  pmc_state_t state_nxt;
  logic [7:0] power_control_r;
  logic [7:0] ctrl_r;
  logic fe_flag_r;
  logic [TW-1:0] tmr_r;
  logic [1:0] pulse_r;
  logic rst_fell_r;
  logic [1:0] src_r;
  logic wake_irq_r;
  logic irq_a_q;
  logic irq_b_q;
  logic rst_q;
  logic wr_en;
  logic rd_en;
  logic hit_power_control;
  logic hit_ctrl;
  logic hit_stat;
  logic wake_a;
  logic wake_b;
  logic rst_rise;
  logic src_rise;
  logic [TW-1:0] sut_cyc;
  logic [2:0] sut_sel;

  // ==========================================================
  // Start-up timeout selection
  // ==========================================================
  assign sut_sel = {crystal_sel, sut_fuse};

  always_comb begin
    case (sut_sel)
      3'h0: sut_cyc = TW'(SUT_RC0);
      3'h1: sut_cyc = TW'(SUT_RC1);
      3'h2: sut_cyc = TW'(SUT_RC2);
      3'h3: sut_cyc = TW'(SUT_RC3);
      3'h4: sut_cyc = TW'(SUT_XT0);
      3'h5: sut_cyc = TW'(SUT_XT1);
      3'h6: sut_cyc = TW'(SUT_XT2);
      default: sut_cyc = TW'(SUT_XT3);
    endcase
  end

  // ==========================================================
  // APB slave, zero wait states
  // ==========================================================
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    hit_power_control = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      hit_power_control = 1'b0;
    end else if (paddr[11:2] == `PMC_POWER_CONTROL_IDX) begin
      hit_power_control = 1'b1;
    end else if (paddr[11:2] == `PMC_CTRL_IDX) begin
      hit_ctrl = 1'b1;
    end else if (paddr[11:2] == `PMC_STAT_IDX) begin
      hit_stat = 1'b1;
    end
  end

  assign pslverr = psel && penable && !(hit_power_control || hit_ctrl ||
                   (hit_stat && !pwrite));

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_power_control) begin
      prdata[7:0] = power_control_r;
    end else if (hit_ctrl) begin
      prdata[7:0] = ctrl_r;
    end else if (hit_stat) begin
      prdata[2:0] = state_r;
      prdata[4:3] = src_r;
      prdata[7] = fe_flag_r;
    end
  end

  // ==========================================================
  // Pin edge detection
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_q <= 1'b1;
      irq_b_q <= 1'b1;
      rst_q <= 1'b0;
    end else begin
      irq_a_q <= ext_irq_a;
      irq_b_q <= ext_irq_b;
      rst_q <= rst_pin;
    end
  end

  assign wake_a = irq_a_q && !ext_irq_a && ctrl_r[`PMC_B_ENA] &&
                  !ctrl_r[`PMC_B_TYPA];
  assign wake_b = irq_b_q && !ext_irq_b && ctrl_r[`PMC_B_ENB] &&
                  !ctrl_r[`PMC_B_TYPB];
  assign rst_rise = rst_pin && !rst_q;
  assign src_rise = src_r[0] ? (ext_irq_a && !irq_a_q) :
                    (ext_irq_b && !irq_b_q);

  // ==========================================================
  // Mode sequencer
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMC_ST_RUN: begin
        if (instr_done && power_control_r[`PMC_B_PD]) begin
          state_nxt = PMC_ST_PD;
        end else if (instr_done && power_control_r[`PMC_B_IDLE]) begin
          state_nxt = PMC_ST_IDLE;
        end
      end
      PMC_ST_IDLE: begin
        if (irq_pending) begin
          state_nxt = PMC_ST_RUN;
        end
      end
      PMC_ST_PD: begin
        // reset pin takes precedence over interrupts
        if (rst_rise) begin
          state_nxt = PMC_ST_WAKE_R;
        end else if (wake_a || wake_b) begin
          if (power_control_r[`PMC_B_WTIME]) begin
            state_nxt = PMC_ST_WAKE_T;
          end else begin
            state_nxt = PMC_ST_WAKE_E;
          end
        end
      end
      PMC_ST_WAKE_T: begin
        if (tmr_r <= TW'(1)) begin
          state_nxt = PMC_ST_RUN;
        end
      end
      PMC_ST_WAKE_E: begin
        if (src_rise) begin
          state_nxt = PMC_ST_RUN;
        end
      end
      PMC_ST_WAKE_R: begin
        // choose pulse or hold at timeout
        if (tmr_r <= TW'(1)) begin
          if (rst_fell_r || !rst_pin) begin
            state_nxt = PMC_ST_RST_PULSE;
          end else begin
            state_nxt = PMC_ST_RST_HOLD;
          end
        end
      end
      PMC_ST_RST_HOLD: begin
        if (!rst_pin) begin
          state_nxt = PMC_ST_RUN;
        end
      end
      PMC_ST_RST_PULSE: begin
        if (pulse_r == 2'd1) begin
          state_nxt = PMC_ST_RUN;
        end
      end
      default: state_nxt = PMC_ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PMC_ST_RUN;
    end else if (warm_rst) begin
      state_r <= PMC_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake timer loaded on entry, counts down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= '0;
    end else if (state_r == PMC_ST_PD) begin
      tmr_r <= sut_cyc;
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - TW'(1);
    end
  end

  // remember an early fall of the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_fell_r <= 1'b0;
    end else if (state_r != PMC_ST_WAKE_R) begin
      rst_fell_r <= 1'b0;
    end else if (!rst_pin) begin
      rst_fell_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 2'd0;
    end else if (state_nxt == PMC_ST_RST_PULSE &&
                 state_r != PMC_ST_RST_PULSE) begin
      pulse_r <= `PMC_RST_PULSE_CYC;
    end else if (pulse_r != 2'd0) begin
      pulse_r <= pulse_r - 2'd1;
    end
  end

  // Source of the power-down wake, bit 0 for pin a and bit 1 for pin b.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= 2'd0;
    end else if (state_r == PMC_ST_PD && !rst_rise) begin
      if (wake_a) begin
        src_r <= 2'd1;
      end else if (wake_b) begin
        src_r <= 2'd2;
      end
    end
  end

  // interrupt is serviced as soon as the CPU clock returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_irq_r <= 1'b0;
    end else begin
      wake_irq_r <= (state_r == PMC_ST_WAKE_T ||
                     state_r == PMC_ST_WAKE_E) &&
                    state_nxt == PMC_ST_RUN && !warm_rst;
    end
  end

  // ==========================================================
  // Power control register
  // ==========================================================
  // cold flag is one after power-up; warm reset spares it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_r <= `PMC_POWER_CONTROL_RST | (8'h01 << `PMC_B_COLD);
    end else if (warm_rst) begin
      power_control_r <= `PMC_POWER_CONTROL_RST | (power_control_r & (8'h01 << `PMC_B_COLD));
    end else if (wr_en && hit_power_control) begin
      power_control_r <= pwdata[7:0];
    end else begin
      if (state_r == PMC_ST_IDLE && state_nxt == PMC_ST_RUN) begin
        power_control_r[`PMC_B_IDLE] <= 1'b0;
      end
      if (state_r != PMC_ST_RUN && state_r != PMC_ST_IDLE &&
          state_r != PMC_ST_PD && state_nxt == PMC_ST_RUN) begin
        power_control_r[`PMC_B_PD] <= 1'b0;
        power_control_r[`PMC_B_IDLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `PMC_CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_r <= pwdata[7:0] & 8'h1F;
    end
  end

  // framing flag sets whatever the select bit holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_flag_r <= 1'b0;
    end else if (fe_event) begin
      fe_flag_r <= 1'b1;
    end else if (fe_clear) begin
      fe_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // serial control bit 7 view
  assign serial_bit7 = power_control_r[`PMC_B_FESEL] ? fe_flag_r :
                       serial_mode_bit;
  // baud doubler to the serial port
  assign baud_double_bit = power_control_r[`PMC_B_BAUD2];

  // CPU clock halted; core state stays in its own flops
  // the program counter is reset only by cpu_rst on a reset wake, so otherwise execution resumes
  // after the sleep instruction once the handler returns.
  assign cpu_clk_en = state_r == PMC_ST_RUN ||
                      state_r == PMC_ST_RST_HOLD ||
                      state_r == PMC_ST_RST_PULSE;
  // oscillator, detector and flash off in power-down
  assign osc_en = state_r != PMC_ST_PD;
  // detector follows the oscillator, so it stays on in idle
  assign bod_en = state_r != PMC_ST_PD;
  assign flash_pd = state_r == PMC_ST_PD;
  // peripherals keep their clock only in run and idle
  assign periph_clk_en = state_r == PMC_ST_RUN ||
                         state_r == PMC_ST_IDLE;
  // watchdog in idle follows its control bit
  assign wdt_run = state_r == PMC_ST_RUN ||
                   (state_r == PMC_ST_IDLE && ctrl_r[`PMC_B_WDI]);
  assign cpu_rst = state_r == PMC_ST_RST_HOLD ||
                   state_r == PMC_ST_RST_PULSE;
  assign wake_irq = wake_irq_r;
  assign wake_src = src_r;
  assign mode_state = state_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  a_pd_power_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_PD |-> !osc_en && !bod_en && flash_pd)
    else $error("power-down left a domain running");

  a_idle_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_IDLE |-> !cpu_clk_en && bod_en && periph_clk_en)
    else $error("idle clocking wrong");

  a_wdt_idle: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_IDLE |-> wdt_run == ctrl_r[`PMC_B_WDI])
    else $error("watchdog ignores idle control");

  a_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_IDLE && irq_pending && !warm_rst && !wr_en
    |=> state_r == PMC_ST_RUN && !power_control_r[`PMC_B_IDLE])
    else $error("idle wake failed");

  a_enter_pd: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_RUN && instr_done && power_control_r[`PMC_B_PD] &&
    !warm_rst |=> state_r == PMC_ST_PD)
    else $error("power-down not entered");

  a_timed_wake: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_PD && !rst_rise && (wake_a || wake_b) &&
    power_control_r[`PMC_B_WTIME] && !warm_rst
    |=> state_r == PMC_ST_WAKE_T && !cpu_clk_en && osc_en)
    else $error("timed wake not started");

  a_ext_wake: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PMC_ST_WAKE_E && !src_rise |=> state_r != PMC_ST_RUN ||
    $past(warm_rst))
    else $error("clock released before pin rose");

  a_rst_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    state_r != PMC_ST_RST_PULSE ##1 state_r == PMC_ST_RST_PULSE &&
    !warm_rst |-> cpu_rst ##1 cpu_rst ##1 !cpu_rst || warm_rst)
    else $error("internal reset pulse not two cycles");

  a_cold_keep: assert property (@(posedge pclk) disable iff (!presetn)
    warm_rst |=> power_control_r[`PMC_B_COLD] == $past(power_control_r[`PMC_B_COLD]))
    else $error("warm reset changed cold flag");

  a_fe_set: assert property (@(posedge pclk) disable iff (!presetn)
    fe_event |=> fe_flag_r)
    else $error("framing flag not set");

endmodule : pmc_power_mode_controller
`default_nettype wire

// >>> verification/pmc_far_side_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Far side: CPU sequencing, interrupt pins and reset pin
// ==========================================================
module pmc_far_side_model (
  input wire logic pclk,
  output logic instr_done,
  output logic irq_pending,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic rst_pin
);
  // The interrupt pins rest high on pull-ups and the reset pin rests low.
  initial begin
    instr_done = 1'b0;
    irq_pending = 1'b0;
    ext_irq_a = 1'b1;
    ext_irq_b = 1'b1;
    rst_pin = 1'b0;
  end

  // The CPU flags the last cycle of the instruction that wrote the request.
  task automatic end_instr();
    @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
  endtask : end_instr

  task automatic set_irq(input logic lvl);
    @(posedge pclk);
    irq_pending <= lvl;
  endtask : set_irq

  // active time chosen by caller
  // Select 0 and 1 pull an interrupt pin low, select 2 raises reset.
  task automatic pin_act(input int sel, input int cycles);
    @(posedge pclk);
    if (sel == 0) ext_irq_a <= 1'b0;
    else if (sel == 1) ext_irq_b <= 1'b0;
    else rst_pin <= 1'b1;
    repeat (cycles) @(posedge pclk);
    ext_irq_a <= 1'b1;
    ext_irq_b <= 1'b1;
    rst_pin <= 1'b0;
  endtask : pin_act
endmodule : pmc_far_side_model

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.svh"

`define TB_CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module testbench;
  import pmc_pkg::*;
  // Short start-up counts keep every wake-up within a few cycles.
  localparam int SUT[8] = '{4, 6, 8, 10, 5, 7, 9, 11};
  localparam logic [11:0] A_POWER_CONTROL = {`PMC_POWER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_CTRL = {`PMC_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {`PMC_STAT_IDX, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, instr_done, irq_pending, warm_rst = 1'b0;
  logic ext_irq_a, ext_irq_b, rst_pin, serial_bit7, baud_double_bit;
  logic [1:0] sut_fuse = 2'h0;
  logic crystal_sel = 1'b0;
  logic fe_event = 1'b0;
  logic fe_clear = 1'b0;
  logic serial_mode_bit = 1'b0;
  logic cpu_clk_en, periph_clk_en, wdt_run, osc_en, bod_en, flash_pd;
  logic cpu_rst, wake_irq, w, err;
  logic [1:0] wake_src;
  logic [31:0] rd, r;
  logic [7:0] v;
  pmc_state_t mode_state;
  int fails = 0;
  int comparisons = 0;
  int seed = 37436;
  int cyc = 0;
  int k, n, h, sel;

  always #10 pclk = ~pclk;

  pmc_power_mode_controller #(
    .SUT_RC0(SUT[0]), .SUT_RC1(SUT[1]), .SUT_RC2(SUT[2]), .SUT_RC3(SUT[3]),
    .SUT_XT0(SUT[4]), .SUT_XT1(SUT[5]), .SUT_XT2(SUT[6]), .SUT_XT3(SUT[7])
  ) i_pmc_power_mode_controller (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_done(instr_done),
    .irq_pending(irq_pending), .warm_rst(warm_rst), .ext_irq_a(ext_irq_a),
    .ext_irq_b(ext_irq_b), .rst_pin(rst_pin), .sut_fuse(sut_fuse),
    .crystal_sel(crystal_sel), .fe_event(fe_event), .fe_clear(fe_clear),
    .serial_mode_bit(serial_mode_bit), .serial_bit7(serial_bit7),
    .baud_double_bit(baud_double_bit), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .wdt_run(wdt_run), .osc_en(osc_en),
    .bod_en(bod_en), .flash_pd(flash_pd), .cpu_rst(cpu_rst),
    .wake_irq(wake_irq), .wake_src(wake_src), .mode_state(mode_state)
  );

  pmc_far_side_model i_pmc_far_side_model (
    .pclk(pclk), .instr_done(instr_done), .irq_pending(irq_pending),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .rst_pin(rst_pin)
  );

  // ==========================================================
  // Bench tasks
  // ==========================================================
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic sleep(input logic [7:0] d);
    apb(1'b1, A_POWER_CONTROL, d);
    i_pmc_far_side_model.end_instr();
    @(negedge pclk);
    if (d[1]) begin
      `TB_CHK(osc_en, 1'b0)
      `TB_CHK(bod_en, 1'b0)
      `TB_CHK(flash_pd, 1'b1)
      `TB_CHK(cpu_clk_en, 1'b0)
    end
  endtask : sleep

  // Waits, with a bound, for the sequencer to reach the run state.
  task automatic wait_run(output int cnt);
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while (mode_state !== PMC_ST_RUN && cnt < 300);
  endtask : wait_run

  task automatic timed_wake(input int s, input int nn);
    sleep(8'h32);
    i_pmc_far_side_model.pin_act(s, 1);
    wait_run(k);
    `TB_CHK(k, nn + 1)
    `TB_CHK(wake_irq, 1'b1)
    `TB_CHK(wake_src, 2'(s + 1))
    apb(1'b0, A_POWER_CONTROL, 8'h00);
    `TB_CHK(rd[7:0], 8'h30)
  endtask : timed_wake

  function automatic int sut(input logic [1:0] f, input logic x);
    return SUT[{x, f}];
  endfunction : sut

  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // A hung wait is cut short here and counted as a mismatch.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_POWER_CONTROL, 8'h00);
    `TB_CHK(rd, 32'h00000010)
    apb(1'b0, 12'h000, 8'h00);
    `TB_CHK(err, 1'b1)
    apb(1'b1, A_STAT, 8'hFF);
    `TB_CHK(err, 1'b1)
    apb(1'b0, A_POWER_CONTROL + 12'h001, 8'h00);
    `TB_CHK(err, 1'b1)
    @(posedge pclk);
    fe_event <= 1'b1;
    @(posedge pclk);
    fe_event <= 1'b0;
    apb(1'b0, A_STAT, 8'h00);
    `TB_CHK(rd[7], 1'b1)
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      v = r[7:0] & 8'hFC;
      @(posedge pclk);
      serial_mode_bit <= r[8];
      apb(1'b1, A_POWER_CONTROL, v);
      apb(1'b0, A_POWER_CONTROL, 8'h00);
      `TB_CHK(rd[7:0], v)
      `TB_CHK(baud_double_bit, v[7])
      `TB_CHK(serial_bit7, v[6] ? 1'b1 : r[8])
    end
    @(posedge pclk);
    fe_clear <= 1'b1;
    @(posedge pclk);
    fe_clear <= 1'b0;
    apb(1'b0, A_STAT, 8'h00);
    `TB_CHK(rd[7], 1'b0)
    apb(1'b1, A_POWER_CONTROL, 8'h1C);
    @(posedge pclk);
    warm_rst <= 1'b1;
    @(posedge pclk);
    warm_rst <= 1'b0;
    apb(1'b0, A_POWER_CONTROL, 8'h00);
    `TB_CHK(rd[7:0], 8'h10)
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, A_CTRL, (i == 0) ? 8'h13 : 8'h03);
      apb(1'b1, A_POWER_CONTROL, 8'h11);
      repeat (4) @(negedge pclk);
      `TB_CHK(mode_state, PMC_ST_RUN)
      i_pmc_far_side_model.end_instr();
      @(negedge pclk);
      `TB_CHK(mode_state, PMC_ST_IDLE)
      `TB_CHK(cpu_clk_en, 1'b0)
      `TB_CHK(periph_clk_en, 1'b1)
      `TB_CHK(bod_en, 1'b1)
      if (i == 0) w = wdt_run;
      else `TB_CHK(wdt_run, ~w)
      i_pmc_far_side_model.set_irq(1'b1);
      repeat (2) @(negedge pclk);
      `TB_CHK(mode_state, PMC_ST_RUN)
      i_pmc_far_side_model.set_irq(1'b0);
      apb(1'b0, A_POWER_CONTROL, 8'h00);
      `TB_CHK(rd[7:0], 8'h10)
    end
    $display("test idle done");
    timed_wake(0, sut(sut_fuse, crystal_sel));
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      @(posedge pclk);
      sut_fuse <= r[1:0];
      crystal_sel <= r[2];
      timed_wake(int'(r[3]), sut(r[1:0], r[2]));
    end
    $display("test timed wake done");
    n = sut(sut_fuse, crystal_sel);
    sleep(8'h12);
    i_pmc_far_side_model.pin_act(1, n + 6);
    @(negedge pclk);
    `TB_CHK(mode_state, PMC_ST_WAKE_E)
    `TB_CHK(cpu_clk_en, 1'b0)
    `TB_CHK(osc_en, 1'b1)
    wait_run(k);
    `TB_CHK(k <= 2, 1'b1)
    `TB_CHK(wake_src, 2'h2)
    $display("test external wake done");
    // Pin a is disabled and pin b is edge-typed, so neither may wake.
    apb(1'b1, A_CTRL, 8'h0A);
    sleep(8'h12);
    i_pmc_far_side_model.pin_act(0, 2);
    i_pmc_far_side_model.pin_act(1, 2);
    repeat (3) @(negedge pclk);
    `TB_CHK(mode_state, PMC_ST_PD)
    i_pmc_far_side_model.pin_act(2, 1);
    k = 0;
    h = 0;
    do begin
      @(negedge pclk);
      k++;
      if (cpu_rst === 1'b1) h++;
    end while (mode_state !== PMC_ST_RUN && k < 300);
    `TB_CHK(h, 2)
    `TB_CHK(k > n, 1'b1)
    sleep(8'h12);
    i_pmc_far_side_model.pin_act(2, n + 8);
    @(negedge pclk);
    `TB_CHK(cpu_rst, 1'b1)
    `TB_CHK(mode_state, PMC_ST_RST_HOLD)
    wait_run(k);
    `TB_CHK(k <= 2, 1'b1)
    `TB_CHK(cpu_rst, 1'b0)
    $display("test reset wake done");
    summarize();
  end
endmodule : testbench

`default_nettype wire
